// File: core/cis_pkg.sv
// cis_pkg: constants shared by the interrupt selector files
// assumes a 32-bit apb register bus and a 32-line event vector
package cis_pkg;
    // register byte addresses
    localparam logic [31:0] CIS_ADDR_SEL_HIGH = 32'h019C0000;
    localparam logic [31:0] CIS_ADDR_SEL_LOW = 32'h019C0004;
    localparam logic [31:0] CIS_ADDR_IRQ_STATUS = 32'h019C0008;
    localparam logic [31:0] CIS_ADDR_IRQ_ENABLE = 32'h019C000C;
    localparam logic [31:0] CIS_ADDR_IRQ_CLEAR = 32'h019C0010;
    // selector geometry
    localparam int CIS_SEL_W = 5;
    localparam int CIS_FIELDS = 6;
    localparam int CIS_FIELD_LO1 = 0;
    localparam int CIS_FIELD_LO2 = 5;
    localparam int CIS_FIELD_LO3 = 10;
    localparam int CIS_FIELD_LO4 = 16;
    localparam int CIS_FIELD_LO5 = 21;
    localparam int CIS_FIELD_LO6 = 26;
    localparam int CIS_FIRST_PROG = 4;
    localparam int CIS_NUM_CPU_IRQ = 16;
    localparam int CIS_NUM_EVENTS = 32;
    // reset selector values for cpu irq 4..9 (low) and 10..15 (high)
    localparam logic [31:0] CIS_RST_SEL_LOW = 32'h250718A4;
    localparam logic [31:0] CIS_RST_SEL_HIGH = 32'h08202D43;
    // reserved selector codes
    localparam logic [4:0] CIS_CODE_RSV_A = 5'h15;
    localparam logic [4:0] CIS_CODE_RSV_B = 5'h16;
    localparam logic [4:0] CIS_CODE_RSV_LO = 5'h18;
    localparam logic [4:0] CIS_CODE_RSV_HI = 5'h1D;
    // status bit positions
    localparam int CIS_ST_RSV_LOW = 0;
    localparam int CIS_ST_RSV_HIGH = 1;
    localparam logic [31:0] CIS_ZERO = 32'h00000000;
    localparam logic [1:0] CIS_ST_ZERO = 2'h0;
endpackage : cis_pkg

// File: core/cis_route.sv
// cis_route: registered event-to-cpu-interrupt routing
// assumes synchronised events and selector words on ref_clk_i
`timescale 1ns/100ps
module cis_route
    import cis_pkg::*;
(
    input wire logic ref_clk_i, // core clock
    input wire logic srst_i, // sync reset, active high
    input wire logic [31:0] evt_i, // synchronised event lines
    input wire logic reset_evt_i, // synchronised reset event
    input wire logic nmi_evt_i, // synchronised nmi event
    cis_sel_if.route sel, // selector words
    output logic [15:0] cpu_irq_o // registered cpu inputs
);
    // field start of the n-th selector inside its word
    function automatic int field_lo(input int n);
        int r;
        r = CIS_FIELD_LO1;
        unique case (n)
            0: r = CIS_FIELD_LO1;
            1: r = CIS_FIELD_LO2;
            2: r = CIS_FIELD_LO3;
            3: r = CIS_FIELD_LO4;
            4: r = CIS_FIELD_LO5;
            default: r = CIS_FIELD_LO6;
        endcase
        return r;
    endfunction : field_lo

    logic [15:0] next_irq; // combinational routing result

    // fixed and programmable routing
    always_comb begin
        next_irq = '0;
        next_irq[0] = reset_evt_i;
        next_irq[1] = nmi_evt_i;
        // 2 and 3 stay low: reserved inputs
        for (int i = 0; i < CIS_FIELDS; i++) begin
            next_irq[CIS_FIRST_PROG + i] =
                evt_i[sel.sel_low[field_lo(i) +: CIS_SEL_W]];
            next_irq[CIS_FIRST_PROG + CIS_FIELDS + i] =
                evt_i[sel.sel_high[field_lo(i) +: CIS_SEL_W]];
        end
    end

    // one register stage keeps cpu inputs glitch free
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            cpu_irq_o <= '0;
        end else begin
            cpu_irq_o <= next_irq;
        end
    end
endmodule : cis_route

// File: core/cis_sel_if.sv
// cis_sel_if: selector register contents passed to the routing module
// assumes one clock domain shared by both ends
`timescale 1ns/100ps
interface cis_sel_if;
    logic [31:0] sel_low; // selector word for cpu irq 4..9
    logic [31:0] sel_high; // selector word for cpu irq 10..15
    modport regs (output sel_low, output sel_high);
    modport route (input sel_low, input sel_high);
endinterface : cis_sel_if

// File: core/cis_top.sv
// cis_top: cpu interrupt selector with apb registers
// assumes an apb master on ref_clk_i and asynchronous event pins
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/100ps
module cis_top
    import cis_pkg::*;
(
    input wire logic ref_clk_i, // 250 mhz core clock
    input wire logic srst_i, // sync reset, active high
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [31:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error, unmapped address
    input wire logic [31:0] evt_i, // event lines, by selector code
    input wire logic reset_evt_i, // reset event to cpu irq 0
    input wire logic nmi_evt_i, // nmi event to cpu irq 1
    output logic [15:0] cpu_irq_o, // cpu interrupt inputs
    output logic irq_o // reserved-code interrupt
);
    // code meanings 0 host, 1..2 timers, 3 mem a refresh
    // 4..7 pin events, 8 transfer done, 9..11 debug, 12..15 serial0/1,
    // 16 pin event zero, 17..18 serial2, 19 timer two, 20 mem b refresh,
    // 23 cell bus, 30 viterbi unit, 31 turbo unit

    // true when a code is one software must not use
    function automatic logic is_rsv(input logic [4:0] c);
        return (c == CIS_CODE_RSV_A) || (c == CIS_CODE_RSV_B) ||
            ((c >= CIS_CODE_RSV_LO) && (c <= CIS_CODE_RSV_HI));
    endfunction : is_rsv

    // true when any field of a word holds a reserved code
    function automatic logic word_rsv(input logic [31:0] w);
        logic r;
        r = 1'b0;
        r = r | is_rsv(w[CIS_FIELD_LO1 +: CIS_SEL_W]);
        r = r | is_rsv(w[CIS_FIELD_LO2 +: CIS_SEL_W]);
        r = r | is_rsv(w[CIS_FIELD_LO3 +: CIS_SEL_W]);
        r = r | is_rsv(w[CIS_FIELD_LO4 +: CIS_SEL_W]);
        r = r | is_rsv(w[CIS_FIELD_LO5 +: CIS_SEL_W]);
        r = r | is_rsv(w[CIS_FIELD_LO6 +: CIS_SEL_W]);
        return r;
    endfunction : word_rsv

    // only the six field slices are stored; gaps read zero
    localparam logic [31:0] CIS_FIELD_MASK = 32'h7FFF7FFF;

    cis_sel_if sel_bus (); // selector words to router

    logic [31:0] evt_meta; // first sync stage, read only by evt_sync
    logic [31:0] evt_sync; // synchronised events
    logic [1:0] fix_meta; // first sync stage for reset and nmi
    logic [1:0] fix_sync; // synchronised reset and nmi
    logic [31:0] sel_low; // low selector word
    logic [31:0] sel_high; // high selector word
    logic [1:0] irq_status; // sticky reserved-code flags
    logic [1:0] irq_enable; // interrupt enables
    logic acc; // apb access phase, single wait-free cycle
    logic wr; // write taken this edge
    logic mapped; // address decodes to a register
    logic [1:0] rsv_evt; // reserved-code write events

    assign acc = psel & penable;
    assign wr = acc & pwrite;
    assign mapped = (paddr == CIS_ADDR_SEL_HIGH) ||
        (paddr == CIS_ADDR_SEL_LOW) || (paddr == CIS_ADDR_IRQ_STATUS) ||
        (paddr == CIS_ADDR_IRQ_ENABLE) || (paddr == CIS_ADDR_IRQ_CLEAR);
    assign rsv_evt[CIS_ST_RSV_LOW] = wr && (paddr == CIS_ADDR_SEL_LOW) &&
        word_rsv(pwdata);
    assign rsv_evt[CIS_ST_RSV_HIGH] = wr && (paddr == CIS_ADDR_SEL_HIGH) &&
        word_rsv(pwdata);
    assign sel_bus.sel_low = sel_low;
    assign sel_bus.sel_high = sel_high;

    // two-stage synchronisers for pin events
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            evt_meta <= CIS_ZERO;
            evt_sync <= CIS_ZERO;
            fix_meta <= CIS_ST_ZERO;
            fix_sync <= CIS_ST_ZERO;
        end else begin
            evt_meta <= evt_i;
            evt_sync <= evt_meta;
            fix_meta <= {nmi_evt_i, reset_evt_i};
            fix_sync <= fix_meta;
        end
    end

    // selector registers; a reserved code is stored anyway, only flagged
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            sel_low <= CIS_RST_SEL_LOW;
            sel_high <= CIS_RST_SEL_HIGH;
        end else if (wr) begin
            if (paddr == CIS_ADDR_SEL_LOW) begin
                sel_low <= pwdata & CIS_FIELD_MASK;
            end
            if (paddr == CIS_ADDR_SEL_HIGH) begin
                sel_high <= pwdata & CIS_FIELD_MASK;
            end
        end
    end

    // sticky status: set wins over clear
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            irq_status <= CIS_ST_ZERO;
        end else begin
            irq_status <= ((wr && paddr == CIS_ADDR_IRQ_CLEAR) ?
                (irq_status & ~pwdata[1:0]) : irq_status) | rsv_evt;
        end
    end

    // enable register
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            irq_enable <= CIS_ST_ZERO;
        end else if (wr && paddr == CIS_ADDR_IRQ_ENABLE) begin
            irq_enable <= pwdata[1:0];
        end
    end

    // level interrupt from registered status
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(irq_status & irq_enable);
        end
    end

    // apb answer: registered at the setup edge, ready in the first access cycle, no wait state
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= CIS_ZERO;
        end else begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped;
            prdata <= CIS_ZERO;
            if (psel && !penable && !pwrite) begin
                if (paddr == CIS_ADDR_SEL_LOW) begin
                    prdata <= sel_low;
                end else if (paddr == CIS_ADDR_SEL_HIGH) begin
                    prdata <= sel_high;
                end else if (paddr == CIS_ADDR_IRQ_STATUS) begin
                    prdata <= {30'h00000000, irq_status};
                end else if (paddr == CIS_ADDR_IRQ_ENABLE) begin
                    prdata <= {30'h00000000, irq_enable};
                end
            end
        end
    end

    // routing of events onto cpu inputs
    cis_route u_route (
        .ref_clk_i(ref_clk_i),
        .srst_i(srst_i),
        .evt_i(evt_sync),
        .reset_evt_i(fix_sync[0]),
        .nmi_evt_i(fix_sync[1]),
        .sel(sel_bus.route),
        .cpu_irq_o(cpu_irq_o)
    );

    // checks
    property p_rst_low;
        @(posedge ref_clk_i) $fell(srst_i) |-> sel_low == CIS_RST_SEL_LOW;
    endproperty
    a_rst_low: assert property (p_rst_low) else $error("low default");
    property p_rst_high;
        @(posedge ref_clk_i) $fell(srst_i) |-> sel_high == CIS_RST_SEL_HIGH;
    endproperty
    a_rst_high: assert property (p_rst_high) else $error("high default");
    property p_fixed_rsv;
        @(posedge ref_clk_i) disable iff (srst_i) cpu_irq_o[3:2] == 2'h0;
    endproperty
    a_fixed_rsv: assert property (p_fixed_rsv) else $error("irq 2/3 set");
    property p_nmi;
        @(posedge ref_clk_i) disable iff (srst_i)
            fix_sync[1] |=> cpu_irq_o[1];
    endproperty
    a_nmi: assert property (p_nmi) else $error("nmi not routed");
    property p_reset_irq;
        @(posedge ref_clk_i) disable iff (srst_i)
            fix_sync[0] |=> cpu_irq_o[0];
    endproperty
    a_reset_irq: assert property (p_reset_irq) else $error("irq0");
    property p_route4;
        @(posedge ref_clk_i) disable iff (srst_i)
            1'b1 |=> cpu_irq_o[4] == $past(evt_sync[sel_low[4:0]]);
    endproperty
    a_route4: assert property (p_route4) else $error("irq4 route");
    property p_route15;
        @(posedge ref_clk_i) disable iff (srst_i)
            1'b1 |=> cpu_irq_o[15] == $past(evt_sync[sel_high[30:26]]);
    endproperty
    a_route15: assert property (p_route15) else $error("irq15");
    property p_wr_low;
        @(posedge ref_clk_i) disable iff (srst_i)
            wr && paddr == CIS_ADDR_SEL_LOW |=>
            sel_low == ($past(pwdata) & CIS_FIELD_MASK);
    endproperty
    a_wr_low: assert property (p_wr_low) else $error("low write");
    property p_new_sel;
        @(posedge ref_clk_i) disable iff (srst_i)
            wr && paddr == CIS_ADDR_SEL_HIGH |=> ##1
            cpu_irq_o[10] == $past(evt_sync[sel_high[4:0]]);
    endproperty
    a_new_sel: assert property (p_new_sel) else $error("sel late");
    property p_rsv_flag;
        @(posedge ref_clk_i) disable iff (srst_i)
            rsv_evt[0] |=> irq_status[0];
    endproperty
    a_rsv_flag: assert property (p_rsv_flag) else $error("rsv flag");
    c_wr_high: cover property (@(posedge ref_clk_i)
        wr && paddr == CIS_ADDR_SEL_HIGH);
    c_irq: cover property (@(posedge ref_clk_i) irq_o);
    c_err: cover property (@(posedge ref_clk_i) pslverr && pready);
endmodule : cis_top

// File: sim/cis_evt_model.sv
// cis_evt_model: peripheral event sources in front of the selector
// assumes the bench sets wanted levels just after a rising edge
`timescale 1ns/100ps
module cis_evt_model (
    input wire logic ref_clk_i, // core clock
    input wire logic [31:0] want_evt_i, // wanted event levels
    input wire logic want_rst_i, // wanted reset event
    input wire logic want_nmi_i, // wanted nmi event
    output logic [31:0] evt_o, // event lines by code
    output logic rst_evt_o, // reset event line
    output logic nmi_evt_o // nmi event line
);
    // sources switch on the clock like on-chip peripherals
    always_ff @(posedge ref_clk_i) begin
        evt_o <= want_evt_i;
        rst_evt_o <= want_rst_i;
        nmi_evt_o <= want_nmi_i;
    end
endmodule : cis_evt_model

// File: sim/test_cpu_interrupt_selector.sv
// test_cpu_interrupt_selector: random and corner tests of cis_top
// assumes zero-wait apb answers and three-cycle event routing
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin n_compared++; if ((gt) !== (ex)) begin \
    bad_count++; $display("mismatch %s exp %h got %h", nm, ex, gt); end end
module test_cpu_interrupt_selector;
    import cis_pkg::*;
    logic ref_clk_i = 0; // core clock
    logic srst_i = 1; // sync reset
    logic psel = 0, penable = 0, pwrite = 0; // apb controls
    logic [31:0] paddr = 0, pwdata = 0; // apb address and data
    logic [31:0] prdata; // apb read data
    logic pready, pslverr, irq_o; // design flags
    logic [15:0] cpu_irq_o; // cpu interrupt inputs
    logic [31:0] want_evt = 0, evt; // event levels
    logic want_rst = 0, want_nmi = 0, rst_evt, nmi_evt; // fixed events
    int bad_count = 0;
    int n_compared = 0;
    logic [31:0] rng = 32'h0000004F; // xorshift state
    logic [31:0] rd; // last read data
    logic er; // last error flag
    logic [4:0] cl [6], ch [6]; // selector codes low, high
    always #2 ref_clk_i = ~ref_clk_i;
    cis_evt_model u_src (.ref_clk_i(ref_clk_i), .want_evt_i(want_evt),
        .want_rst_i(want_rst), .want_nmi_i(want_nmi), .evt_o(evt),
        .rst_evt_o(rst_evt), .nmi_evt_o(nmi_evt));
    cis_top u_dut (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .evt_i(evt), .reset_evt_i(rst_evt),
        .nmi_evt_i(nmi_evt), .cpu_irq_o(cpu_irq_o), .irq_o(irq_o));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs
    // gaps at bits 15 and 31 read as zero
    function automatic logic [31:0] pack(input logic [4:0] f [6]);
        return {1'b0, f[5], f[4], f[3], 1'b0, f[2], f[1], f[0]};
    endfunction : pack
    // software never stores a reserved code in random runs
    function automatic logic [4:0] legal(input logic [4:0] c);
        if (c == 5'h15 || c == 5'h16 || (c >= 5'h18 && c <= 5'h1D)) begin
            return c & 5'h0F;
        end
        return c;
    endfunction : legal
    function automatic logic [15:0] exp_irq(input logic [31:0] ev,
        input logic r, input logic n);
        logic [15:0] e;
        e = {14'h0000, n, r};
        for (int i = 0; i < 6; i++) begin
            e[4 + i] = ev[cl[i]];
            e[10 + i] = ev[ch[i]];
        end
        return e;
    endfunction : exp_irq
    task test_done();
        if (bad_count == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : test_done
    task step(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask : step
    // one apb transfer; data taken at the edge where pready is high
    task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        int k;
        @(posedge ref_clk_i);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk_i);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge ref_clk_i);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) begin
            bad_count++;
            test_done();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // junk in the gap bits must not stick
    task wsel();
        apb(1'b1, 32'h019C0004, pack(cl) | 32'h80008000);
        apb(1'b1, 32'h019C0000, pack(ch) | 32'h80008000);
    endtask : wsel
    initial begin
        repeat (20) @(posedge ref_clk_i);
        srst_i <= 1'b0;
        step(1);
        `CHK("cpu_irq_rst", 16'h0000, cpu_irq_o)
        cl = '{5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09};
        ch = '{5'h03, 5'h0A, 5'h0B, 5'h00, 5'h01, 5'h02};
        apb(1'b0, 32'h019C0004, 32'h0);
        `CHK("sel_low_rst", pack(cl), rd)
        `CHK("mapped_no_err", 1'b0, er)
        apb(1'b0, 32'h019C0000, 32'h0);
        `CHK("sel_high_rst", pack(ch), rd)
        want_evt <= 32'h5A3C96E1;
        step(6);
        `CHK("route_dflt", exp_irq(32'h5A3C96E1, 0, 0), cpu_irq_o)
        apb(1'b0, 32'h019C0FF0, 32'h0);
        `CHK("unmapped_err", 1'b1, er)
        `CHK("unmapped_data", 32'h0, rd)
        // every legal code, alone and against all others
        for (int c = 0; c < 32; c++) begin
            if (legal(c[4:0]) === c[4:0]) begin
                for (int i = 0; i < 6; i++) begin
                    cl[i] = c[4:0];
                    ch[i] = c[4:0];
                end
                wsel();
                want_evt <= 32'h1 << c;
                step(6);
                `CHK("route_one", 16'hFFF0, cpu_irq_o)
                want_evt <= ~(32'h1 << c);
                step(6);
                `CHK("route_zero", 16'h0000, cpu_irq_o)
            end
        end
        // random selectors, events and fixed inputs
        for (int j = 0; j < 40; j++) begin
            for (int i = 0; i < 6; i++) begin
                rng = xs(rng);
                cl[i] = legal(rng[4:0]);
                ch[i] = legal(rng[9:5]);
            end
            wsel();
            apb(1'b0, 32'h019C0004, 32'h0);
            `CHK("sel_low", pack(cl), rd)
            apb(1'b0, 32'h019C0000, 32'h0);
            `CHK("sel_high", pack(ch), rd)
            rng = xs(rng);
            want_evt <= rng;
            want_rst <= rng[3];
            want_nmi <= rng[7];
            step(6);
            `CHK("route_rand", exp_irq(rng, rng[3], rng[7]), cpu_irq_o)
        end
        // reserved code: flagged, masked, enabled, cleared
        cl[0] = 5'h15;
        apb(1'b1, 32'h019C0004, pack(cl));
        step(3);
        `CHK("irq_masked", 1'b0, irq_o)
        apb(1'b1, CIS_ADDR_IRQ_ENABLE, 32'h3);
        step(3);
        `CHK("irq_on", 1'b1, irq_o)
        apb(1'b0, CIS_ADDR_IRQ_STATUS, 32'h0);
        `CHK("status", 32'h1, rd)
        cl[0] = 5'h04;
        apb(1'b1, 32'h019C0004, pack(cl));
        apb(1'b1, CIS_ADDR_IRQ_CLEAR, 32'h3);
        step(3);
        `CHK("irq_off", 1'b0, irq_o)
        test_done();
    end
endmodule : test_cpu_interrupt_selector
